//--- hw/ebs_pkg.sv
// Purpose: Shared constants and types for the external bus select block
// Assumes: 32-bit external data, 22-bit word address, six memory banks
// Notes:   Strap codes and pin idle levels live here only
package ebs_pkg;

    localparam int          EBS_NUM_BANKS   = 6;
    localparam int          EBS_ADDR_W      = 22;
    localparam int          EBS_DATA_W      = 32;
    localparam int          EBS_BE_W        = 4;
    localparam int          EBS_ACCESS_CYC  = 2;

    // Boot bank width strap codes
    localparam logic [1:0]  EBS_STRAP_RSVD  = 2'h0;
    localparam logic [1:0]  EBS_STRAP_BYTE  = 2'h1;
    localparam logic [1:0]  EBS_STRAP_HALF  = 2'h2;
    localparam logic [1:0]  EBS_STRAP_WORD  = 2'h3;

    // Reset and idle pin levels
    localparam logic [5:0]  EBS_CS_IDLE     = 6'h3F;
    localparam logic [3:0]  EBS_WBE_IDLE    = 4'hF;
    localparam logic        EBS_STROBE_IDLE = 1'h1;
    localparam logic        EBS_LITTLE_RST  = 1'h0;

    typedef enum logic [1:0] {
        EBS_W_BYTE = 2'h0,
        EBS_W_HALF = 2'h1,
        EBS_W_WORD = 2'h2
    } ebs_width_type;

    typedef enum logic [1:0] {
        EBS_K_ROM   = 2'h0,
        EBS_K_DRAM  = 2'h1,
        EBS_K_SDRAM = 2'h2
    } ebs_kind_type;

    typedef enum logic [3:0] {
        EBS_ST_IDLE   = 4'h1,
        EBS_ST_ACCESS = 4'h2,
        EBS_ST_FLOAT  = 4'h4,
        EBS_ST_GRANT  = 4'h8
    } ebs_state_type;

    typedef struct packed {
        logic                    write;
        ebs_kind_type            kind;
        logic [2:0]              bank;
        logic [EBS_BE_W-1:0]     be;
        logic [EBS_ADDR_W-1:0]   addr;
        logic [EBS_DATA_W-1:0]   wdata;
    } ebs_req_type;

endpackage : ebs_pkg

//--- hw/ebs_sync2.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are quasi-static or slow against core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ebs_sync2 import ebs_pkg::*; #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = rst_b ? async_in : RST_VAL;
        sync_nxt = rst_b ? meta_r : RST_VAL;
    end

    always_ff @(posedge core_clk) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign sync_out = sync_r;

endmodule : ebs_sync2

//--- hw/ebs_handoff.sv
// Purpose: External memory bank selects, strobes, straps and bus handoff
// Assumes: One access at a time from the core; straps static after reset
// Notes:   bus_drive_en low floats every external bus pin
// Function
// R1: One active-low chip select per ROM/SRAM/flash bank, six banks.
// R2: Boot bank width from strap: 01 byte, 10 half, 11 word, 00 reserved.
// R3: Output enable driven low to selected memory during accesses; the code drives it low on reads only, high on writes.
// R4: Byte write enables on non-DRAM writes; DRAM writes use DRAM write enable.
// R5: Byte write enables act as SDRAM data masks on SDRAM accesses.
// R6: External master request floats all external bus pins.
// R7: External master refreshes DRAM itself while it holds the bus.
// R8: Request dropped: acknowledge goes low and device retakes the bus.
// R9: Endian strap high selects little-endian, low big-endian by default.
// R10: Acknowledge goes high once pins are floated for a request.
`timescale 1ns/1ps
module ebs_handoff import ebs_pkg::*; #(
    parameter int ACCESS_CYCLES = EBS_ACCESS_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  acc_valid,
    output logic                       acc_ready,
    input  wire ebs_req_type           acc_req,
    output logic [EBS_DATA_W-1:0]      rd_data,
    output logic                       rd_valid,
    output logic [EBS_NUM_BANKS-1:0]   bank_chip_select_n,
    output logic                       output_enable_n,
    output logic [EBS_BE_W-1:0]        byte_write_enable_n,
    output logic                       dram_write_enable_n,
    output logic [EBS_ADDR_W-1:0]      addr_out,
    output logic [EBS_DATA_W-1:0]      xdata_out,
    output logic                       xdata_oe,
    input  wire logic [EBS_DATA_W-1:0] xdata_in,
    output logic                       bus_drive_en,
    input  wire logic                  ext_master_request,
    output logic                       ext_master_acknowledge,
    input  wire logic [1:0]            boot_bank_width_strap,
    input  wire logic                  little_endian_strap,
    output ebs_width_type              boot_bank_width,
    output logic                       boot_width_reserved,
    output logic                       little_endian,
    output logic                       straps_valid
);

    localparam logic [7:0] CNT_LAST = 8'(ACCESS_CYCLES - 1);
    // Edges for the strap synchroniser to fill after release
    localparam logic [1:0] STRAP_FILL = 2'h2;

    function automatic logic [5:0] bank_dec(input logic [2:0] bank);
        bank_dec = (bank < 3'(EBS_NUM_BANKS)) ? 6'(6'h01 << bank) : 6'h00;
    endfunction : bank_dec

    function automatic logic [31:0] lane_swap(input logic [31:0] d,
                                              input logic        lil);
        lane_swap = lil ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction : lane_swap

    logic        mreq_s;
    logic [2:0]  strap_s;

    ebs_sync2 #(.W(1), .RST_VAL(1'h0)) u_sync_req (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (ext_master_request),
        .sync_out (mreq_s)
    );

    // Strap pull-down is in the pad; a floating pin arrives here low
    ebs_sync2 #(.W(3), .RST_VAL(3'h0)) u_sync_strap (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({little_endian_strap, boot_bank_width_strap}),
        .sync_out (strap_s)
    );

    // Strap capture
    logic [1:0]    strap_cnt_r,  strap_cnt_nxt;
    logic          straps_ok_r,  straps_ok_nxt;
    ebs_width_type width_r,      width_nxt;
    logic          rsvd_r,       rsvd_nxt;
    logic          little_r,     little_nxt;

    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        straps_ok_nxt = straps_ok_r;
        width_nxt     = width_r;
        rsvd_nxt      = rsvd_r;
        little_nxt    = little_r;
        if (!rst_b) begin
            strap_cnt_nxt = 2'h0;
            straps_ok_nxt = 1'h0;
            width_nxt     = EBS_W_WORD;
            rsvd_nxt      = 1'h0;
            little_nxt    = EBS_LITTLE_RST;
        end else if (strap_cnt_r != STRAP_FILL) begin
            // Reset value still in the second stage until then
            strap_cnt_nxt = strap_cnt_r + 2'h1;
        end else if (!straps_ok_r) begin
            straps_ok_nxt = 1'h1;
            little_nxt    = strap_s[2];               // see R9
            rsvd_nxt      = (strap_s[1:0] == EBS_STRAP_RSVD);
            case (strap_s[1:0])                       // see R2
                EBS_STRAP_BYTE: width_nxt = EBS_W_BYTE;
                EBS_STRAP_HALF: width_nxt = EBS_W_HALF;
                EBS_STRAP_WORD: width_nxt = EBS_W_WORD;
                default:        width_nxt = EBS_W_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        strap_cnt_r <= strap_cnt_nxt;
        straps_ok_r <= straps_ok_nxt;
        width_r     <= width_nxt;
        rsvd_r      <= rsvd_nxt;
        little_r    <= little_nxt;
    end

    // Access and handoff machine
    ebs_state_type   state_r,  state_nxt;
    logic [7:0]      cnt_r,    cnt_nxt;
    ebs_req_type     req_r,    req_nxt;
    logic [5:0]      cs_n_r,   cs_n_nxt;
    logic            oe_n_r,   oe_n_nxt;
    logic [3:0]      wbe_n_r,  wbe_n_nxt;
    logic            dwe_n_r,  dwe_n_nxt;
    logic            xoe_r,    xoe_nxt;
    logic [31:0]     xdo_r,    xdo_nxt;
    logic [31:0]     rdat_r,   rdat_nxt;
    logic            rdv_r,    rdv_nxt;
    logic            ack_r,    ack_nxt;
    logic            drv_r,    drv_nxt;

    assign acc_ready = (state_r == EBS_ST_IDLE) && !mreq_s && straps_ok_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        req_nxt   = req_r;
        cs_n_nxt  = cs_n_r;
        oe_n_nxt  = oe_n_r;
        wbe_n_nxt = wbe_n_r;
        dwe_n_nxt = dwe_n_r;
        xoe_nxt   = xoe_r;
        xdo_nxt   = xdo_r;
        rdat_nxt  = rdat_r;
        rdv_nxt   = 1'h0;
        ack_nxt   = ack_r;
        drv_nxt   = drv_r;
        case (state_r)
            EBS_ST_IDLE: begin
                if (mreq_s) begin
                    // Strobes are idle here, so floating is glitch free
                    drv_nxt   = 1'h0;                 // see R6
                    state_nxt = EBS_ST_FLOAT;
                end else if (acc_valid && acc_ready) begin
                    req_nxt   = acc_req;
                    cnt_nxt   = CNT_LAST;
                    state_nxt = EBS_ST_ACCESS;
                    if (acc_req.kind == EBS_K_ROM) begin
                        cs_n_nxt = ~bank_dec(acc_req.bank);   // see R1
                    end
                    oe_n_nxt = acc_req.write;                 // see R3
                    case (acc_req.kind)
                        EBS_K_ROM:   wbe_n_nxt = acc_req.write ?
                                         ~acc_req.be : EBS_WBE_IDLE; // see R4
                        EBS_K_SDRAM: wbe_n_nxt = ~acc_req.be;        // see R5
                        default:     wbe_n_nxt = EBS_WBE_IDLE;
                    endcase
                    dwe_n_nxt = !((acc_req.kind != EBS_K_ROM)
                                  && acc_req.write);         // see R4
                    xoe_nxt   = acc_req.write;
                    xdo_nxt   = lane_swap(acc_req.wdata, little_r); // see R9
                end
            end
            EBS_ST_ACCESS: begin
                if (cnt_r == 8'h00) begin
                    rdat_nxt  = lane_swap(xdata_in, little_r);
                    rdv_nxt   = !req_r.write;
                    cs_n_nxt  = EBS_CS_IDLE;
                    oe_n_nxt  = EBS_STROBE_IDLE;
                    wbe_n_nxt = EBS_WBE_IDLE;
                    dwe_n_nxt = EBS_STROBE_IDLE;
                    xoe_nxt   = 1'h0;
                    state_nxt = EBS_ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            EBS_ST_FLOAT: begin
                ack_nxt   = 1'h1;                     // see R10
                state_nxt = EBS_ST_GRANT;
            end
            EBS_ST_GRANT: begin
                // Far master owns refresh while granted, see R7
                if (!mreq_s) begin
                    ack_nxt   = 1'h0;                 // see R8
                    drv_nxt   = 1'h1;
                    state_nxt = EBS_ST_IDLE;
                end
            end
            default: state_nxt = EBS_ST_IDLE;
        endcase
        if (!rst_b) begin
            state_nxt = EBS_ST_IDLE;
            cnt_nxt   = 8'h00;
            req_nxt   = '0;
            cs_n_nxt  = EBS_CS_IDLE;
            oe_n_nxt  = EBS_STROBE_IDLE;
            wbe_n_nxt = EBS_WBE_IDLE;
            dwe_n_nxt = EBS_STROBE_IDLE;
            xoe_nxt   = 1'h0;
            xdo_nxt   = 32'h0000_0000;
            rdat_nxt  = 32'h0000_0000;
            rdv_nxt   = 1'h0;
            ack_nxt   = 1'h0;
            drv_nxt   = 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        state_r <= state_nxt;
        cnt_r   <= cnt_nxt;
        req_r   <= req_nxt;
        cs_n_r  <= cs_n_nxt;
        oe_n_r  <= oe_n_nxt;
        wbe_n_r <= wbe_n_nxt;
        dwe_n_r <= dwe_n_nxt;
        xoe_r   <= xoe_nxt;
        xdo_r   <= xdo_nxt;
        rdat_r  <= rdat_nxt;
        rdv_r   <= rdv_nxt;
        ack_r   <= ack_nxt;
        drv_r   <= drv_nxt;
    end

    assign bank_chip_select_n     = cs_n_r;
    assign output_enable_n        = oe_n_r;
    assign byte_write_enable_n    = wbe_n_r;
    assign dram_write_enable_n    = dwe_n_r;
    assign addr_out               = req_r.addr;
    assign xdata_out              = xdo_r;
    assign xdata_oe               = xoe_r && drv_r;
    assign bus_drive_en           = drv_r;
    assign ext_master_acknowledge = ack_r;
    assign rd_data                = rdat_r;
    assign rd_valid               = rdv_r;
    assign boot_bank_width        = width_r;
    assign boot_width_reserved    = rsvd_r;
    assign little_endian          = little_r;
    assign straps_valid           = straps_ok_r;

    // Checks
    sequence s_float_then_ack;
        !drv_r && !ack_r ##1 !drv_r && ack_r;
    endsequence

    property p_cs_onehot;
        @(posedge core_clk) disable iff (!rst_b)
        $onehot0(~cs_n_r);
    endproperty
    a_cs_onehot: assert property (p_cs_onehot) // see R1
        else $error("more than one bank chip select active");

    property p_boot_byte;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(straps_ok_r) && ($past(strap_s[1:0]) == EBS_STRAP_BYTE)
            |-> (width_r == EBS_W_BYTE) && !rsvd_r;
    endproperty
    a_boot_byte: assert property (p_boot_byte) // see R2
        else $error("byte strap not decoded as byte width");

    property p_oe_read;
        @(posedge core_clk) disable iff (!rst_b)
        (state_r == EBS_ST_ACCESS) |-> (oe_n_r == req_r.write);
    endproperty
    a_oe_read: assert property (p_oe_read) // see R3
        else $error("output enable wrong during access");

    property p_dram_no_wbe;
        @(posedge core_clk) disable iff (!rst_b)
        (state_r == EBS_ST_ACCESS) && (req_r.kind == EBS_K_DRAM)
            |-> (wbe_n_r == EBS_WBE_IDLE) && (dwe_n_r == !req_r.write);
    endproperty
    a_dram_no_wbe: assert property (p_dram_no_wbe) // see R4
        else $error("DRAM access used byte write enables");

    property p_sdram_mask;
        @(posedge core_clk) disable iff (!rst_b)
        (state_r == EBS_ST_ACCESS) && (req_r.kind == EBS_K_SDRAM)
            |-> (wbe_n_r == ~req_r.be);
    endproperty
    a_sdram_mask: assert property (p_sdram_mask) // see R5
        else $error("SDRAM mask does not follow byte lanes");

    property p_float_on_req;
        @(posedge core_clk) disable iff (!rst_b)
        (state_r == EBS_ST_IDLE) && mreq_s |=> s_float_then_ack;
    endproperty
    a_float_on_req: assert property (p_float_on_req) // see R6
        else $error("pins not floated before acknowledge");

    property p_release;
        @(posedge core_clk) disable iff (!rst_b)
        ack_r && !mreq_s |=> !ack_r && drv_r && !xdata_oe;
    endproperty
    a_release: assert property (p_release) // see R8
        else $error("bus not retaken after request dropped");

    property p_little;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(straps_ok_r) |-> (little_r == $past(strap_s[2]));
    endproperty
    a_little: assert property (p_little) // see R9
        else $error("endian strap not captured");

    property p_ack_floated;
        @(posedge core_clk) disable iff (!rst_b)
        ack_r |-> !drv_r && (cs_n_r == EBS_CS_IDLE) && !$past(drv_r);
    endproperty
    a_ack_floated: assert property (p_ack_floated) // see R10
        else $error("acknowledge high while device drives bus");

endmodule : ebs_handoff

//--- verif/ebs_far_model.sv
// Purpose: Far side model: one memory device and an external bus master
// Assumes: Memory answers combinationally while output enable is low and the bus is driven, whatever the chip select
// Notes:   Released data bus shows a toggling pattern, not the last word
`timescale 1ns/1ps
module ebs_far_model import ebs_pkg::*; (
    input  wire logic                  core_clk,
    input  wire logic                  output_enable_n,
    input  wire logic                  bus_drive_en,
    input  wire logic                  ext_master_acknowledge,
    input  wire logic                  want_bus,
    output logic [EBS_DATA_W-1:0]      xdata_in,
    output logic                       ext_master_request,
    output logic [7:0]                 refresh_cnt
);
    localparam logic [31:0] MEM_WORD = 32'h11223344;
    logic [31:0] alt_r = 32'h5A5A5A5A;

    assign xdata_in = (!output_enable_n && bus_drive_en) ? MEM_WORD : alt_r;
    initial ext_master_request = 1'b0;
    initial refresh_cnt = 8'h00;

    always @(posedge core_clk) begin
        alt_r <= ~alt_r;
        // Raise request while want_bus is high; drop it once want_bus is low and acknowledge is high
        if (want_bus)
            ext_master_request <= 1'b1;
        else if (ext_master_acknowledge)
            ext_master_request <= 1'b0;
        // Refresh DRAM while holding the bus
        if (ext_master_acknowledge && ext_master_request)
            refresh_cnt <= refresh_cnt + 8'h01;
    end
endmodule : ebs_far_model

//--- verif/testbench.sv
// Purpose: Self-checking bench for the bus select and handoff block
// Assumes: Inputs driven on falling edges; memory word from the model
// Notes:   Endian strap held low at start like its pull-down
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    err_total++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end end
module testbench;
    import ebs_pkg::*;
    localparam int AC = 2;
    logic core_clk = 1'b0, rst_b = 1'b0, acc_valid = 1'b0, want = 1'b0;
    logic acc_ready, rd_valid, oe_n, dwe_n, xdata_oe, drv, mreq, ack;
    logic [1:0] strap = 2'h3;
    logic little_in = 1'b0, rsvd, little, svalid;
    ebs_req_type acc_req = '0;
    ebs_width_type bw;
    logic [31:0] rd_data, xd_out, xd_in;
    logic [5:0] cs_n;
    logic [3:0] wbe_n;
    logic [21:0] addr;
    logic [7:0] rcnt;
    int err_total = 0, n_tests = 0;
    ebs_width_type wtab [4] = '{EBS_W_WORD, EBS_W_BYTE, EBS_W_HALF,
                               EBS_W_WORD};

    initial forever #4 core_clk = ~core_clk;

    ebs_handoff #(.ACCESS_CYCLES(AC)) ebs_handoff_inst (
        .core_clk(core_clk), .rst_b(rst_b), .acc_valid(acc_valid),
        .acc_ready(acc_ready), .acc_req(acc_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .bank_chip_select_n(cs_n),
        .output_enable_n(oe_n), .byte_write_enable_n(wbe_n),
        .dram_write_enable_n(dwe_n), .addr_out(addr),
        .xdata_out(xd_out), .xdata_oe(xdata_oe), .xdata_in(xd_in),
        .bus_drive_en(drv), .ext_master_request(mreq),
        .ext_master_acknowledge(ack), .boot_bank_width_strap(strap),
        .little_endian_strap(little_in), .boot_bank_width(bw),
        .boot_width_reserved(rsvd), .little_endian(little),
        .straps_valid(svalid));

    ebs_far_model ebs_far_model_inst (
        .core_clk(core_clk), .output_enable_n(oe_n), .bus_drive_en(drv),
        .ext_master_acknowledge(ack), .want_bus(want), .xdata_in(xd_in),
        .ext_master_request(mreq), .refresh_cnt(rcnt));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic rst_run(input logic [1:0] s, input logic le);
        strap = s;
        little_in = le;
        rst_b = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask : rst_run

    function automatic ebs_req_type mk(input logic w, input ebs_kind_type k,
                                       input logic [2:0] b,
                                       input logic [3:0] be);
        return '{write: w, kind: k, bank: b, be: be,
                 addr: 22'h0001A0 + 22'(b), wdata: 32'hCAFE0000};
    endfunction : mk

    task automatic do_acc(input ebs_req_type r);
        int i;
        acc_req = r;
        acc_valid = 1'b1;
        for (i = 0; i < 20 && acc_ready !== 1'b1; i++) @(negedge core_clk);
        if (i == 20) begin
            err_total++;
            finish_test();
        end
        @(negedge core_clk);
        acc_valid = 1'b0;
    endtask : do_acc

    task automatic t_straps();
        for (int c = 0; c < 4; c++) begin
            rst_run(2'(c), 1'b0);
            `CHK("svalid", 1'b1, svalid);
            `CHK("width", wtab[c], bw);
            `CHK("rsvd", (c == 0), rsvd);
            `CHK("little", 1'b0, little);
            `CHK("cs idle", 6'h3F, cs_n);
            `CHK("ack idle", 1'b0, ack);
        end
    endtask : t_straps

    task automatic t_rom_read(input logic le, input logic [31:0] exp);
        for (int b = 0; b < 7; b++) begin
            do_acc(mk(1'b0, EBS_K_ROM, 3'(b), 4'hF));
            `CHK("cs", (b < 6) ? ~(6'h01 << b) : 6'h3F, cs_n);
            `CHK("oe", 1'b0, oe_n);
            `CHK("addr", 22'h0001A0 + 22'(b), addr);
            repeat (AC) @(negedge core_clk);
            `CHK("rd_valid", 1'b1, rd_valid);
            `CHK("rd_data", exp, rd_data);
            `CHK("little", le, little);
        end
    endtask : t_rom_read

    task automatic t_writes();
        do_acc(mk(1'b1, EBS_K_ROM, 3'h2, 4'h5));
        `CHK("cs wr", 6'h3B, cs_n);
        `CHK("wbe rom", 4'hA, wbe_n);
        `CHK("dwe rom", 1'b1, dwe_n);
        `CHK("oe wr", 1'b1, oe_n);
        `CHK("xoe", 1'b1, xdata_oe);
        `CHK("xdata", 32'hCAFE0000, xd_out);
        repeat (AC) @(negedge core_clk);
        do_acc(mk(1'b1, EBS_K_DRAM, 3'h0, 4'h3));
        `CHK("wbe dram", 4'hF, wbe_n);
        `CHK("dwe dram", 1'b0, dwe_n);
        `CHK("cs dram", 6'h3F, cs_n);
        repeat (AC) @(negedge core_clk);
        do_acc(mk(1'b0, EBS_K_SDRAM, 3'h0, 4'h3));
        `CHK("dqm", 4'hC, wbe_n);
        `CHK("oe sd", 1'b0, oe_n);
        repeat (AC) @(negedge core_clk);
        do_acc(mk(1'b1, EBS_K_SDRAM, 3'h0, 4'h6));
        `CHK("dqm wr", 4'h9, wbe_n);
        `CHK("dwe sd", 1'b0, dwe_n);
        repeat (AC) @(negedge core_clk);
    endtask : t_writes

    task automatic t_handoff();
        int i;
        want = 1'b1;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge core_clk);
        `CHK("ack up", 1'b1, ack);
        `CHK("float", 1'b0, drv);
        `CHK("xoe float", 1'b0, xdata_oe);
        `CHK("refused", 1'b0, acc_ready);
        repeat (5) @(negedge core_clk);
        `CHK("refresh", 1'b1, rcnt != 8'h00);
        `CHK("still", 1'b0, drv);
        want = 1'b0;
        for (i = 0; i < 20 && ack !== 1'b0; i++) @(negedge core_clk);
        `CHK("ack down", 1'b0, ack);
        `CHK("retake", 1'b1, drv);
        do_acc(mk(1'b0, EBS_K_ROM, 3'h0, 4'hF));
        `CHK("cs back", 6'h3E, cs_n);
        repeat (AC) @(negedge core_clk);
    endtask : t_handoff

    initial begin
        t_straps();
        t_rom_read(1'b0, 32'h11223344);
        t_writes();
        t_handoff();
        rst_run(2'h1, 1'b1);
        t_rom_read(1'b1, 32'h44332211);
        finish_test();
    end
endmodule : testbench
